// [obc_regs.vh]
`ifndef OBC_REGS_VH
`define OBC_REGS_VH
// byte addresses of the configuration row
`define OBC_ADDR_READOUT    16'h4800
`define OBC_ADDR_UNUSED     16'h4801
`define OBC_ADDR_BOOT       16'h4802
`define OBC_ADDR_DATA       16'h4803
`define OBC_ADDR_PCODE      16'h4807
`define OBC_ADDR_DOG        16'h4808
// factory defaults
`define OBC_RST_READOUT     8'haa
`define OBC_RST_ZERO        8'h00
// size byte meaning no area, and the first boot size that write-protects
`define OBC_SIZE_NONE       8'h00
`define OBC_BOOT_WPROT_MIN  8'h03
// readout lock off value
`define OBC_READOUT_OPEN    8'haa
// watchdog byte fields
`define OBC_DOG_INDEP_HW    0
`define OBC_DOG_INDEP_HALT  1
`define OBC_DOG_WIN_HW      2
`define OBC_DOG_WIN_HALT    3
`define OBC_DOG_MASK        8'h0f
// program space boundaries
`define OBC_PROG_BASE       16'h8000
`define OBC_PROG_TOP        16'hbfff
`define OBC_PAGE_SHIFT      6
`define OBC_PCODE_BASE      16'h8080
`define OBC_PCODE_TOP_MAX   16'hbfbf
`endif

// [obc_option_bytes.v]
`timescale 1ns/100ps
`include "obc_regs.vh"
module obc_option_bytes (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire        clk_en,
    input  wire        in_circuit_programming_mode,
    input  wire        prog_wr,
    input  wire        prog_rd,
    input  wire [15:0] prog_addr,
    input  wire [7:0]  prog_wdata,
    output reg  [7:0]  prog_rdata,
    output reg         prog_wr_reject,
    output reg         readout_lock,
    output reg         boot_area_en,
    output reg         boot_area_wprot,
    output reg  [15:0] boot_area_top,
    output reg         data_area_en,
    output reg  [15:0] data_area_base,
    output reg         pcode_area_en,
    output reg  [15:0] pcode_area_top,
    output reg         indep_dog_hw_start,
    output reg         indep_dog_halt_stop,
    output reg         window_dog_hw_start,
    output reg         window_dog_halt_run
);
    // the row is a register model of the non-volatile bytes; the programmer
    // reaches it with one-cycle strobes on the system clock, and only the
    // mode pin crosses in from the debug domain
    //
    // limitation: a relocked row stays locked, since this model offers no
    // erase path to reopen it

    // the configuration row sits outside the reset domain: what the programmer
    // writes survives every system reset, and power-up shows the factory values
    reg [7:0]  readout_protection_byte_reg  = `OBC_RST_READOUT;
    reg [7:0]  boot_area_size_byte_reg      = `OBC_RST_ZERO;
    reg [7:0]  data_area_size_byte_reg      = `OBC_RST_ZERO;
    reg [7:0]  protected_code_size_byte_reg = `OBC_RST_ZERO;
    reg [7:0]  watchdog_config_byte_reg     = `OBC_RST_ZERO;

    // set by the one capture edge after each reset release
    reg        load_done_reg;

    // mode pin comes from the debug domain, so synchronise it
    reg        icp_meta_reg;
    reg        icp_sync_reg;

    // access qualifiers
    wire       row_open;
    wire       wr_ok;
    wire       rd_hit;

    // read path
    reg [7:0]  rdata_next;

    // boundary arithmetic, all in 16-bit byte addresses
    reg [15:0] boot_top_next;
    reg [15:0] data_base_next;
    reg [15:0] pcode_top_next;

    // decoded flags waiting for the capture edge
    reg        lock_next;
    reg        boot_en_next;
    reg        boot_wprot_next;
    reg        data_en_next;
    reg        pcode_en_next;
    reg [3:0]  dog_next;

    // two-flop synchroniser; only the second stage feeds any logic
    // the mode takes two edges to arrive, so the first write it allows lands on edge three
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            icp_meta_reg <= 1'b0;
            icp_sync_reg <= 1'b0;
        end else if (clk_en) begin
            icp_meta_reg <= in_circuit_programming_mode;
            icp_sync_reg <= icp_meta_reg;
        end
    end

    // the live readout byte gates writes, so a relock shuts the row at once
    // instead of waiting for the next reset
    assign row_open = (readout_protection_byte_reg == `OBC_READOUT_OPEN);
    // writes need the synchronised debug mode and an open row; nothing
    // else in the part can reach the store
    assign wr_ok    = prog_wr && icp_sync_reg && row_open;
    // reads carry no check of their own
    assign rd_hit   = prog_rd;

    // byte store; deliberately without reset, because a reset that wiped the
    // row would leave the capture edge nothing to load; a relock via the
    // readout byte is allowed as the last unlocked write
    always @(posedge clk_sys) begin
        if (clk_en && wr_ok) begin
            case (prog_addr)
                `OBC_ADDR_READOUT: readout_protection_byte_reg  <= prog_wdata;
                `OBC_ADDR_BOOT:    boot_area_size_byte_reg      <= prog_wdata;
                `OBC_ADDR_DATA:    data_area_size_byte_reg      <= prog_wdata;
                `OBC_ADDR_PCODE:   protected_code_size_byte_reg <= prog_wdata;
                // reserved upper bits of the watchdog byte are never stored
                `OBC_ADDR_DOG:     watchdog_config_byte_reg     <= prog_wdata & `OBC_DOG_MASK;
                // the spare byte and unmapped addresses are dropped without a reject
                default:           readout_protection_byte_reg  <= readout_protection_byte_reg;
            endcase
        end
    end

    // read mux; unused byte and unmapped addresses read zero
    // the read path ignores the lock; guarding program memory is the flash controller's job
    always @* begin
        case (prog_addr)
            `OBC_ADDR_READOUT: rdata_next = readout_protection_byte_reg;
            `OBC_ADDR_BOOT:    rdata_next = boot_area_size_byte_reg;
            `OBC_ADDR_DATA:    rdata_next = data_area_size_byte_reg;
            `OBC_ADDR_PCODE:   rdata_next = protected_code_size_byte_reg;
            `OBC_ADDR_DOG:     rdata_next = watchdog_config_byte_reg;
            default:           rdata_next = 8'h00;
        endcase
    end

    // read data holds until the next read; the reject flag is a one-cycle pulse
    // and a write refused for either reason raises the same reject
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prog_rdata     <= 8'h00;
            prog_wr_reject <= 1'b0;
        end else if (clk_en) begin
            if (rd_hit) begin
                prog_rdata <= rdata_next;
            end
            prog_wr_reject <= prog_wr && !wr_ok;
        end
    end

    // pages are 64 bytes counted from the program base; the boot area ends
    // on the last byte of its last page, so sizes 1 and 2 cover only vectors
    always @* begin
        boot_top_next = `OBC_PROG_BASE +
                        ({8'h00, boot_area_size_byte_reg} << `OBC_PAGE_SHIFT) - 16'h0001;
    end

    // the data area grows down from the top of program space
    always @* begin
        data_base_next = `OBC_PROG_TOP + 16'h0001 -
                         ({8'h00, data_area_size_byte_reg} << `OBC_PAGE_SHIFT);
    end

    // the protected area starts at the trap vector and ends on its last page;
    // the clamp keeps an out-of-range size inside program space
    always @* begin
        pcode_top_next = `OBC_PROG_BASE +
                         ({8'h00, protected_code_size_byte_reg} << `OBC_PAGE_SHIFT) - 16'h0001;
        if (pcode_top_next > `OBC_PCODE_TOP_MAX) begin
            pcode_top_next = `OBC_PCODE_TOP_MAX;
        end
    end

    // flag decode; the watchdog bits pass straight through, but the window
    // watchdog halt bit has the opposite sense to the independent one, so
    // the two halt outputs must not be wired to the same kind of control
    always @* begin
        lock_next       = !row_open;
        boot_en_next    = (boot_area_size_byte_reg != `OBC_SIZE_NONE);
        // sizes 1 and 2 reserve only vectors, so protection starts at 3
        boot_wprot_next = (boot_area_size_byte_reg >= `OBC_BOOT_WPROT_MIN);
        data_en_next    = (data_area_size_byte_reg != `OBC_SIZE_NONE);
        // a nonzero size may leave program reads unreliable after reset; decoded anyway
        pcode_en_next   = (protected_code_size_byte_reg != `OBC_SIZE_NONE);
        dog_next        = watchdog_config_byte_reg[3:0];
    end

    // capture once after reset release; later writes wait for the next reset,
    // so the flash controller and both watchdogs see settings that never move
    // a low clock enable at release only delays the capture edge
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            load_done_reg       <= 1'b0;
            readout_lock        <= 1'b0;
            boot_area_en        <= 1'b0;
            boot_area_wprot     <= 1'b0;
            boot_area_top       <= 16'h0000;
            data_area_en        <= 1'b0;
            data_area_base      <= 16'h0000;
            pcode_area_en       <= 1'b0;
            pcode_area_top      <= 16'h0000;
            indep_dog_hw_start  <= 1'b0;
            indep_dog_halt_stop <= 1'b0;
            window_dog_hw_start <= 1'b0;
            window_dog_halt_run <= 1'b0;
        end else if (clk_en && !load_done_reg) begin
            load_done_reg       <= 1'b1;
            readout_lock        <= lock_next;
            boot_area_en        <= boot_en_next;
            boot_area_wprot     <= boot_wprot_next;
            boot_area_top       <= boot_top_next;
            data_area_en        <= data_en_next;
            data_area_base      <= data_base_next;
            pcode_area_en       <= pcode_en_next;
            pcode_area_top      <= pcode_top_next;
            indep_dog_hw_start  <= dog_next[`OBC_DOG_INDEP_HW];
            indep_dog_halt_stop <= dog_next[`OBC_DOG_INDEP_HALT];
            window_dog_hw_start <= dog_next[`OBC_DOG_WIN_HW];
            window_dog_halt_run <= dog_next[`OBC_DOG_WIN_HALT];
        end
    end
endmodule // obc_option_bytes

// [obc_checker.sv]
`timescale 1ns/100ps
module obc_checker (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        clk_en,
    input wire logic        in_circuit_programming_mode,
    input wire logic        prog_wr,
    input wire logic        prog_wr_reject,
    input wire logic        readout_lock,
    input wire logic        boot_area_en,
    input wire logic        boot_area_wprot,
    input wire logic        data_area_en,
    input wire logic        pcode_area_en,
    input wire logic [15:0] boot_area_top,
    input wire logic [15:0] data_area_base,
    input wire logic [15:0] pcode_area_top
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // two stages, since the load edge itself may still move the outputs
    logic [1:0]  ld_reg;
    wire  [48:0] dec = {readout_lock, boot_area_top, data_area_base, pcode_area_top};
    always @(posedge clk_sys or negedge nrst)
        if (!nrst) ld_reg <= 2'b00;
        else if (clk_en) ld_reg <= {ld_reg[0], 1'b1};
    hold_set_a: assert property (ld_reg[1] |-> $stable(dec))
        else $error("settings moved");
    boot_wp_a: assert property (boot_area_wprot |-> boot_area_top >= 16'h80bf)
        else $error("boot protect");
    boot_top_a: assert property (boot_area_en |-> boot_area_top[5:0] == 6'h3f)
        else $error("boot top");
    data_base_a: assert property (data_area_en |-> data_area_base[5:0] == 6'h00)
        else $error("data base");
    pcode_top_a: assert property (pcode_area_en |-> pcode_area_top <= 16'hbfbf)
        else $error("pcode top");
    mode_rej_a: assert property ((!in_circuit_programming_mode && clk_en)[*3] ##0 prog_wr
        |=> prog_wr_reject) else $error("mode reject");
    lock_rej_a: assert property (readout_lock && prog_wr && clk_en |=> prog_wr_reject)
        else $error("lock reject");
    rej_cause_a: assert property (prog_wr_reject && $past(clk_en) |-> $past(prog_wr))
        else $error("stray reject");
    cover property (prog_wr_reject);
    cover property (readout_lock);
    cover property (boot_area_wprot && data_area_en);
endmodule // obc_checker
bind obc_option_bytes obc_checker obc_checker_i (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .in_circuit_programming_mode(in_circuit_programming_mode), .prog_wr(prog_wr),
    .prog_wr_reject(prog_wr_reject), .readout_lock(readout_lock),
    .boot_area_en(boot_area_en), .boot_area_wprot(boot_area_wprot),
    .data_area_en(data_area_en), .pcode_area_en(pcode_area_en),
    .boot_area_top(boot_area_top), .data_area_base(data_area_base),
    .pcode_area_top(pcode_area_top)
);

// [obc_prog.sv]
`timescale 1ns/100ps
module obc_prog (
    input  wire logic        clk_sys,
    output logic             in_circuit_programming_mode,
    output logic             prog_wr,
    output logic             prog_rd,
    output logic      [15:0] prog_addr,
    output logic      [7:0]  prog_wdata
);
    // idle: link mode off, no strobe
    initial {in_circuit_programming_mode, prog_wr, prog_rd, prog_addr, prog_wdata} = 27'h0;
    // only the link in programming mode may write; sync needs 2 edges, the task waits 3
    task automatic set_mode(input logic m);
        in_circuit_programming_mode = m;
        repeat (3) @(negedge clk_sys);
    endtask
    // one-cycle strobe; released lines are scrambled so nothing stale lingers
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {prog_wr, prog_rd, prog_addr, prog_wdata} = {w, !w, a, d};
        @(negedge clk_sys);
        {prog_wr, prog_rd, prog_addr, prog_wdata} = {2'b00, ~a, ~d};
    endtask
    // spare byte always gets zero
    task automatic setup(input logic [7:0] b, ds, pc, dog);
        xfer(1'b1, 16'h4801, 8'h00);
        xfer(1'b1, 16'h4802, b);
        xfer(1'b1, 16'h4803, ds);
        xfer(1'b1, 16'h4807, pc); // zero unless asked for a protected area
        xfer(1'b1, 16'h4808, dog);
    endtask
endmodule // obc_prog

// [tb_top.sv]
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
    logic        clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b1;
    logic        in_circuit_programming_mode, prog_wr, prog_rd, prog_wr_reject, readout_lock;
    logic        boot_area_en, boot_area_wprot, data_area_en, pcode_area_en;
    logic        indep_dog_hw_start, indep_dog_halt_stop, window_dog_hw_start, window_dog_halt_run;
    logic [15:0] prog_addr, boot_area_top, data_area_base, pcode_area_top;
    logic [7:0]  prog_wdata, prog_rdata;
    int          miscompares = 0, checks_done = 0, cycles = 0;
    wire  [3:0]  dogs = {window_dog_halt_run, window_dog_hw_start, indep_dog_halt_stop,
                         indep_dog_hw_start};
    obc_option_bytes obc_option_bytes_i (
        .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
        .in_circuit_programming_mode(in_circuit_programming_mode),
        .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata), .prog_wr_reject(prog_wr_reject), .readout_lock(readout_lock),
        .boot_area_en(boot_area_en), .boot_area_wprot(boot_area_wprot),
        .boot_area_top(boot_area_top), .data_area_en(data_area_en),
        .data_area_base(data_area_base), .pcode_area_en(pcode_area_en),
        .pcode_area_top(pcode_area_top), .indep_dog_hw_start(indep_dog_hw_start),
        .indep_dog_halt_stop(indep_dog_halt_stop), .window_dog_hw_start(window_dog_hw_start),
        .window_dog_halt_run(window_dog_halt_run)
    );
    obc_prog         obc_prog_i (
        .clk_sys(clk_sys), .in_circuit_programming_mode(in_circuit_programming_mode),
        .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_wdata(prog_wdata)
    );
    always #4 clk_sys = ~clk_sys;
    // a hang counts as a failure
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run;
        end
    end
    task automatic complete_run;
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_reset;
        nrst = 1'b0;
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    // new watchdog bits must not show until a reset, then the bytes decode to the given boundaries
    task automatic cfg_case(input logic [7:0] b, ds, pc, dog, input logic [3:0] old,
                            input logic [15:0] btop, dbase, ptop);
        obc_prog_i.setup(b, ds, pc, dog);
        `CHK("dogs before reset", old, dogs)
        do_reset;
        `CHK("boot top", btop, boot_area_top)
        `CHK("boot wprot", b >= 8'h03, boot_area_wprot)
        `CHK("data base", dbase, data_area_base)
        `CHK("pcode top", ptop, pcode_area_top)
        `CHK("dog bits", dog[3:0], dogs)
        `CHK("enables", 3'h7, {boot_area_en, data_area_en, pcode_area_en})
        obc_prog_i.xfer(1'b0, 16'h4808, 8'h00);
        `CHK("dog byte", {4'h0, dog[3:0]}, prog_rdata)
    endtask
    // writes with the mode off or the lock on are turned away
    task automatic lock_case;
        obc_prog_i.set_mode(1'b0);
        obc_prog_i.xfer(1'b1, 16'h4808, 8'h00);
        `CHK("reject mode off", 1'b1, prog_wr_reject)
        obc_prog_i.set_mode(1'b1);
        obc_prog_i.xfer(1'b1, 16'h4800, 8'h00);
        `CHK("reject open", 1'b0, prog_wr_reject)
        do_reset;
        `CHK("lock", 1'b1, readout_lock)
        obc_prog_i.xfer(1'b1, 16'h4808, 8'h00);
        `CHK("reject locked", 1'b1, prog_wr_reject)
        `CHK("dogs kept", 4'ha, dogs)
        obc_prog_i.xfer(1'b0, 16'h4808, 8'h00);
        `CHK("dog byte locked", 8'h0a, prog_rdata)
    endtask
    // a low clock enable freezes everything, so strobes then are lost
    task automatic freeze_case;
        clk_en = 1'b0;
        obc_prog_i.xfer(1'b1, 16'h4808, 8'h03);
        `CHK("reject frozen", 1'b0, prog_wr_reject)
        obc_prog_i.xfer(1'b0, 16'h4802, 8'h00);
        `CHK("rdata frozen", 8'h0a, prog_rdata)
        clk_en = 1'b1;
        obc_prog_i.xfer(1'b0, 16'h4808, 8'h00);
        `CHK("dog byte frozen", 8'h0a, prog_rdata)
    endtask
    // main sequence
    initial begin
        do_reset;
        `CHK("lock default", 1'b0, readout_lock)
        `CHK("enables default", 3'h0, {boot_area_en, data_area_en, pcode_area_en})
        obc_prog_i.set_mode(1'b1);
        cfg_case(8'h03, 8'h20, 8'h03, 8'h05, 4'h0, 16'h80bf, 16'hb800, 16'h80bf);
        cfg_case(8'hff, 8'h01, 8'hff, 8'h0a, 4'h5, 16'hbfbf, 16'hbfc0, 16'hbfbf);
        freeze_case;
        lock_case;
        complete_run;
    end
endmodule // tb_top
